// file: logic/otp_config_bank.sv
// Configuration bank: factory traceability and range bytes, user link byte.
// Assumes the PSI5 command decoder and response logic run on CLK and give
// one-cycle request pulses; nonvolatile cells are modelled as held registers.
// Reserved range codes are kept and reported unchanged; nothing here rejects them.
// Outputs stay safe (PCM low, no pulldown) until the load finishes.
`timescale 1ns/1ps
module otp_config_bank #(
  parameter logic [31:0] TRACE_WORD      = otp_cfg_pkg::TRACE_DFLT,
  parameter logic [2:0]  FULL_SCALE      = 3'h1,
  parameter logic [7:0]  USER_OTP_INIT   = otp_cfg_pkg::USER_RESET,
  parameter int          BLANK_CYCLES    = otp_cfg_pkg::BLANK_CYC
) (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RSTN,
  // Register access from the PSI5 command decoder
  input  wire logic [7:0]              REG_ADDR,
  input  wire logic                    REG_WR,
  input  wire logic [7:0]              REG_WDATA,
  input  wire logic                    REG_RD,
  output logic      [7:0]              REG_RDATA,
  output logic                         REG_RVALID,
  output logic                         REG_WR_REFUSED,
  // Programming command
  input  wire logic                    PROG_EXEC,
  output logic                         PROG_BUSY,
  // Daisy chain status
  input  wire logic                    DAISY_MODE,
  input  wire logic                    CHAIN_ADDR_VALID,
  input  wire logic                    RUN_CMD_SEEN,
  input  wire logic [2:0]              CHAIN_ADDR,
  // Sync pulses and response timing
  input  wire logic                    SYNC_DETECTED,
  input  wire logic                    RESPONSE_DONE,
  output logic                         SYNC_ACCEPT,
  output logic                         SYNC_PULLDOWN_EN,
  // PCM output path
  input  wire logic                    PCM_MOD,
  output logic                         PCM_OUT,
  // Working configuration
  output otp_cfg_pkg::link_cfg_t       CFG,
  output logic                         CFG_VALID,
  output logic      [3:0]              DATA_BITS,
  output logic      [7:0]              BIT_CYCLES,
  output logic      [3:0]              INIT_RANGE_CODE,
  // Integrity checking
  output logic                         FACTORY_CHECK_OK,
  output logic                         USER_CHECK_EN,
  output logic                         USER_CHECK_OK
);

  // Four traceability bytes plus the range byte
  localparam int NFACT = 5;
  // Blanking counter spans the whole fixed time
  localparam int BW    = $clog2(BLANK_CYCLES + 1);

  // Factory array: four traceability bytes then the range byte
  logic [7:0] fact_mem [NFACT];
  logic [7:0] fact_sum;

  // Bank state
  otp_cfg_pkg::bank_state_t state_reg, state_next;
  logic [7:0] otp_user_reg, otp_user_next;   // stored user cell
  logic       otp_par_reg, otp_par_next;     // stored parity of user cell
  logic [7:0] pend_reg, pend_next;           // value awaiting programming
  logic [7:0] work_reg, work_next;           // working configuration
  logic [7:0] range_reg, range_next;         // working range byte
  logic [7:0] sum_reg, sum_next;             // factory check accumulator
  logic [2:0] idx_reg, idx_next;
  logic [7:0] tmr_reg, tmr_next;
  logic       valid_reg, valid_next;
  logic       fok_reg, fok_next;

  // Register answers
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;
  logic       refused_reg, refused_next;

  // Blanking
  logic          blank_reg, blank_next;
  logic          resp_reg, resp_next;
  logic [BW-1:0] bcnt_reg, bcnt_next;
  logic          accept_reg, accept_next;

  // Output path registers
  logic          pcm_reg, pcm_next;
  logic          pd_reg, pd_next;
  logic          pd_allow;
  logic [3:0]    init_word;

  // Field view of the working byte
  otp_cfg_pkg::link_cfg_t cfg_w;

  // Factory contents are mask constants; range upper bits are fixed
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      fact_mem[i] = TRACE_WORD[8*i +: 8];
    end
    fact_mem[4] = {otp_cfg_pkg::RANGE_FIXED, FULL_SCALE};
  end

  // Reference sum over the whole factory area, traceability included
  always_comb begin
    fact_sum = 8'h00;
    for (int i = 0; i < NFACT; i++) begin
      fact_sum = fact_sum ^ fact_mem[i];
    end
  end

  // Working byte viewed as named fields
  assign cfg_w = otp_cfg_pkg::link_cfg_t'(work_reg);

  // Load, programming and readout sequencing
  // A write in the same cycle as PROG_EXEC still lands in pend_reg before
  // the burn, so the decoder needs no cycle between them.
  always_comb begin
    state_next    = state_reg;
    otp_user_next = otp_user_reg;
    otp_par_next  = otp_par_reg;
    pend_next     = pend_reg;
    work_next     = work_reg;
    range_next    = range_reg;
    sum_next      = sum_reg;
    idx_next      = idx_reg;
    tmr_next      = tmr_reg;
    valid_next    = valid_reg;
    fok_next      = fok_reg;
    refused_next  = 1'b0;
    case (state_reg)
      otp_cfg_pkg::ST_LOAD_FACT: begin
        // Walk the factory area before any field is trusted
        sum_next = sum_reg ^ fact_mem[idx_reg];
        if (idx_reg == 3'(NFACT - 1)) begin
          range_next = fact_mem[idx_reg];
          state_next = otp_cfg_pkg::ST_LOAD_USER;
        end else begin
          idx_next = idx_reg + 3'h1;
        end
      end
      otp_cfg_pkg::ST_LOAD_USER: begin
        // Factory verdict and user byte become valid together
        fok_next   = (sum_reg == fact_sum);
        work_next  = otp_user_reg;
        pend_next  = otp_user_reg;
        valid_next = 1'b1;
        state_next = otp_cfg_pkg::ST_IDLE;
      end
      otp_cfg_pkg::ST_IDLE: begin
        if (REG_WR) begin
          // Only the user byte takes writes, and only while unlocked
          if (REG_ADDR == otp_cfg_pkg::ADDR_USER && !work_reg[otp_cfg_pkg::POS_LOCK]) begin
            pend_next = REG_WDATA;
          end else begin
            refused_next = 1'b1;
          end
        end
        // Refused once locked; busy covers burn and readback
        if (PROG_EXEC) begin
          if (work_reg[otp_cfg_pkg::POS_LOCK]) begin
            refused_next = 1'b1;
          end else begin
            tmr_next   = otp_cfg_pkg::PROG_CYC;
            state_next = otp_cfg_pkg::ST_PROGRAM;
          end
        end
      end
      otp_cfg_pkg::ST_PROGRAM: begin
        // Burn the pending byte, lock bit with it
        if (REG_WR) begin
          refused_next = 1'b1;
        end
        if (tmr_reg == 8'h01) begin
          otp_user_next = pend_reg;
          otp_par_next  = ^pend_reg;
          state_next    = otp_cfg_pkg::ST_READOUT;
        end else begin
          tmr_next = tmr_reg - 8'h01;
        end
      end
      otp_cfg_pkg::ST_READOUT: begin
        // Readback makes the stored value the working one
        if (REG_WR) begin
          refused_next = 1'b1;
        end
        work_next  = otp_user_reg;
        pend_next  = otp_user_reg;
        state_next = otp_cfg_pkg::ST_IDLE;
      end
      default: begin
        state_next = otp_cfg_pkg::ST_LOAD_FACT;
      end
    endcase
  end

  // Register reads answer one cycle after the strobe
  // Reads are served in every state, load included
  always_comb begin
    rdata_next  = 8'h00;
    rvalid_next = REG_RD;
    if (REG_RD) begin
      if (REG_ADDR <= otp_cfg_pkg::ADDR_TRACE3) begin
        rdata_next = fact_mem[REG_ADDR[1:0]];
      end else if (REG_ADDR == otp_cfg_pkg::ADDR_RANGE) begin
        rdata_next = range_reg;
      end else if (REG_ADDR == otp_cfg_pkg::ADDR_USER) begin
        rdata_next = pend_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // Sync blanking; nothing is accepted until configuration is loaded
  // Limitation: only RESPONSE_DONE ends blanking, so the response path
  // must report every response it owes.
  always_comb begin
    blank_next  = blank_reg;
    resp_next   = resp_reg;
    bcnt_next   = bcnt_reg;
    accept_next = 1'b0;
    if (!blank_reg) begin
      if (SYNC_DETECTED && valid_reg) begin
        accept_next = 1'b1;
        blank_next  = 1'b1;
        resp_next   = 1'b0;
        bcnt_next   = BW'(BLANK_CYCLES);
      end
    end else begin
      if (bcnt_reg != '0) begin
        bcnt_next = bcnt_reg - BW'(1);
      end
      if (RESPONSE_DONE) begin
        resp_next = 1'b1;
      end
      // Slot mode waits for the response only; else the longer of both
      if (cfg_w.blank_slot) begin
        blank_next = !(resp_reg || RESPONSE_DONE);
      end else begin
        blank_next = !((resp_reg || RESPONSE_DONE) && bcnt_reg <= BW'(1));
      end
    end
  end

  // Output pins held safe until loaded values are in place
  always_comb begin
    if (!valid_reg) begin
      pcm_next = 1'b0;
      pd_next  = 1'b0;
    end else begin
      // Disabled PCM drives low rather than floating
      pcm_next = cfg_w.pcm_en ? PCM_MOD : 1'b0;
      pd_next  = pd_allow;
    end
  end

  // Pulldown permission from the loaded enable
  sync_pulldown_ctrl u_pulldown (
    .sync_pulldown_enable (cfg_w.pulldown_en),
    .daisy_mode           (DAISY_MODE),
    .chain_addr_valid     (CHAIN_ADDR_VALID),
    .run_cmd_seen         (RUN_CMD_SEEN),
    .chain_addr           (CHAIN_ADDR),
    .pulldown_allow       (pd_allow)
  );

  // Initialization word from the working range byte
  // Even codes are reserved but still mapped, so the word is never unknown
  range_code_map u_range_map (
    .full_scale_code (range_reg[2:0]),
    .init_word       (init_word)
  );

  // State registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg    <= otp_cfg_pkg::ST_LOAD_FACT;
      otp_user_reg <= USER_OTP_INIT;
      otp_par_reg  <= ^USER_OTP_INIT;
      pend_reg     <= otp_cfg_pkg::USER_RESET;
      work_reg     <= otp_cfg_pkg::USER_RESET;
      range_reg    <= otp_cfg_pkg::RANGE_RESET;
      sum_reg      <= 8'h00;
      idx_reg      <= 3'h0;
      tmr_reg      <= 8'h00;
      valid_reg    <= 1'b0;
      fok_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
      rvalid_reg   <= 1'b0;
      refused_reg  <= 1'b0;
      blank_reg    <= 1'b0;
      resp_reg     <= 1'b0;
      bcnt_reg     <= '0;
      accept_reg   <= 1'b0;
      pcm_reg      <= 1'b0;
      pd_reg       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      otp_user_reg <= otp_user_next;
      otp_par_reg  <= otp_par_next;
      pend_reg     <= pend_next;
      work_reg     <= work_next;
      range_reg    <= range_next;
      sum_reg      <= sum_next;
      idx_reg      <= idx_next;
      tmr_reg      <= tmr_next;
      valid_reg    <= valid_next;
      fok_reg      <= fok_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      refused_reg  <= refused_next;
      blank_reg    <= blank_next;
      resp_reg     <= resp_next;
      bcnt_reg     <= bcnt_next;
      accept_reg   <= accept_next;
      pcm_reg      <= pcm_next;
      pd_reg       <= pd_next;
    end
  end

  // Traceability bytes feed only reads and the check, never configuration
  assign REG_RDATA        = rdata_reg;
  assign REG_RVALID       = rvalid_reg;
  assign REG_WR_REFUSED   = refused_reg;
  assign PROG_BUSY        = (state_reg == otp_cfg_pkg::ST_PROGRAM) || (state_reg == otp_cfg_pkg::ST_READOUT);
  assign SYNC_ACCEPT      = accept_reg;
  assign SYNC_PULLDOWN_EN = pd_reg;
  assign PCM_OUT          = pcm_reg;
  assign CFG              = cfg_w;
  assign CFG_VALID        = valid_reg;
  assign FACTORY_CHECK_OK = fok_reg;

  // Field decodes for the response path
  assign DATA_BITS  = cfg_w.len8 ? otp_cfg_pkg::LEN_SHORT : otp_cfg_pkg::LEN_LONG;
  assign BIT_CYCLES = cfg_w.baud_high ? otp_cfg_pkg::BIT_CYC_HIGH : otp_cfg_pkg::BIT_CYC_LOW;
  assign INIT_RANGE_CODE = init_word;

  // User array checking switches on with the lock
  assign USER_CHECK_EN = work_reg[otp_cfg_pkg::POS_LOCK];
  // Disagrees only if a stored cell changes after its burn
  assign USER_CHECK_OK = !USER_CHECK_EN || (otp_par_reg == ^otp_user_reg);

endmodule

// file: pkg/otp_cfg_pkg.sv
// What this block does
// - Hold 32-bit traceability word: low 13 bits device index, upper bits lot.
// - Traceability word is covered by the factory area checksum.
// - Traceability word identifies only; it steers no operating behaviour.
// - Range register at 0x04 is read-only: bits 7..3 read 00100, bits 2..0 range.
// - Range codes 001/011/101/111 mean 60/120/240/480 g; even codes reserved.
// - Initialization reports range as four bits: 0001,0111,0010,1000,0011,1001,0100,1010.
// - User config at 0x05 is writable, defaults zero, fields lock down to baud.
// - Lock written one at execute programming: program, read back, refuse later writes.
// - Once locked, error checking of the user array is switched on.
// - PCM enable one passes modulated signal; zero drives the output low.
// - Outside daisy chain, pulldown only when pulldown enable is one.
// - Daisy chain: pulldown on while unaddressed; else after run and address 001 (code also requires pulldown enable one).
// - Latency bit zero times from sync pulse, one from the time slot.
// - Data size bit zero gives 10 data bits, one gives 8.
// - After accepted sync, ignore syncs per blanking bit rule.
// - Checksum select zero is even parity, one is three-bit CRC.
// - Baud bit zero gives 125 kBaud, one gives 190.5 kBaud.
// - User locations programmable and all registers readable over the PSI5 link.
//
// Shared constants and types of the configuration bank.
// Assumes a single 20 MHz clock for every user of it.
package otp_cfg_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_TRACE0  = 8'h00;
  localparam logic [7:0] ADDR_TRACE3  = 8'h03;
  localparam logic [7:0] ADDR_RANGE   = 8'h04;
  localparam logic [7:0] ADDR_USER    = 8'h05;

  // Reset values and fixed pattern
  localparam logic [7:0] RANGE_RESET  = 8'h20;
  localparam logic [4:0] RANGE_FIXED  = 5'h04;
  localparam logic [7:0] USER_RESET   = 8'h00;
  localparam int         TRACE_IDX_W  = 13;
  localparam logic [31:0] TRACE_DFLT  = 32'h0000_2001;

  // Field positions in the user configuration byte
  localparam int POS_LOCK    = 7;
  localparam int POS_PCM     = 6;
  localparam int POS_PULLDN  = 5;
  localparam int POS_LATENCY = 4;
  localparam int POS_LEN8    = 3;
  localparam int POS_BLANK   = 2;
  localparam int POS_CRC     = 1;
  localparam int POS_BAUD    = 0;

  // Response data lengths
  localparam logic [3:0] LEN_LONG  = 4'hA;
  localparam logic [3:0] LEN_SHORT = 4'h8;

  // Timing in native units, cycles derived from the clock
  localparam int CLK_HZ         = 20000000;
  localparam int BAUD_LOW_HZ    = 125000;
  localparam int BAUD_HIGH_MHZ  = 190500000;
  localparam logic [7:0] BIT_CYC_LOW  = 8'(CLK_HZ / BAUD_LOW_HZ);
  localparam logic [7:0] BIT_CYC_HIGH = 8'((64'(CLK_HZ) * 1000) / BAUD_HIGH_MHZ);
  localparam int BLANK_TIME_NS  = 100000;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int BLANK_CYC      = BLANK_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_TIME_NS   = 1000;
  localparam logic [7:0] PROG_CYC = 8'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Range code to initialization data word
  localparam logic [3:0] INIT_RANGE_MAP [8] = '{4'h1, 4'h7, 4'h2, 4'h8, 4'h3, 4'h9, 4'h4, 4'hA};

  // Bank sequencing
  typedef enum logic [2:0] {ST_LOAD_FACT, ST_LOAD_USER, ST_IDLE, ST_PROGRAM, ST_READOUT} bank_state_t;

  // Decoded working configuration
  typedef struct packed {
    logic       lock;
    logic       pcm_en;
    logic       pulldown_en;
    logic       latency_slot;
    logic       len8;
    logic       blank_slot;
    logic       crc_sel;
    logic       baud_high;
  } link_cfg_t;

endpackage

// file: logic/range_code_map.sv
// Maps the three-bit full-scale code to the four-bit initialization word.
// Assumes the code is stable; purely combinational.
`timescale 1ns/1ps
module range_code_map (
  // Range code in
  input  wire logic [2:0] full_scale_code,
  // Initialization word out
  output logic      [3:0] init_word
);

  // Table lookup, reserved codes included
  always_comb begin
    init_word = otp_cfg_pkg::INIT_RANGE_MAP[full_scale_code];
  end

endmodule

// file: logic/sync_pulldown_ctrl.sv
// Decides whether the sync pulse pulldown may be applied.
// Assumes chain address and run status come from same-clock link logic.
`timescale 1ns/1ps
module sync_pulldown_ctrl (
  // Configuration
  input  wire logic       sync_pulldown_enable,
  input  wire logic       daisy_mode,
  // Daisy chain status
  input  wire logic       chain_addr_valid,
  input  wire logic       run_cmd_seen,
  input  wire logic [2:0] chain_addr,
  // Permission out
  output logic            pulldown_allow
);

  localparam logic [2:0] FIRST_ADDR = 3'h1;

  // With the enable set, chain members pull down while unaddressed, then only after run at the first node
  always_comb begin
    if (!sync_pulldown_enable) begin
      pulldown_allow = 1'b0;
    end else if (!daisy_mode) begin
      pulldown_allow = 1'b1;
    end else if (!chain_addr_valid) begin
      pulldown_allow = 1'b1;
    end else begin
      pulldown_allow = run_cmd_seen && (chain_addr == FIRST_ADDR);
    end
  end

endmodule

// file: verification/otp_bank_chk.sv
// Checker of the configuration bank, watching only its top-level ports.
// Assumes one clock domain, CLK, with async active-low RSTN.
`timescale 1ns/1ps
module otp_bank_chk #(
  parameter int BLANK_CYCLES = 8
) (
  // Clock and reset
  input logic                    CLK,
  input logic                    RSTN,
  // Register access
  input logic [7:0]              REG_ADDR,
  input logic                    REG_WR,
  input logic                    REG_RD,
  input logic [7:0]              REG_RDATA,
  input logic                    REG_RVALID,
  input logic                    REG_WR_REFUSED,
  // Programming
  input logic                    PROG_EXEC,
  input logic                    PROG_BUSY,
  // Sync and pulldown
  input logic                    DAISY_MODE,
  input logic                    CHAIN_ADDR_VALID,
  input logic                    RUN_CMD_SEEN,
  input logic                    RESPONSE_DONE,
  input logic                    SYNC_ACCEPT,
  input logic                    SYNC_PULLDOWN_EN,
  // Outputs of the working configuration
  input logic                    PCM_MOD,
  input logic                    PCM_OUT,
  input otp_cfg_pkg::link_cfg_t  CFG,
  input logic                    CFG_VALID,
  input logic [3:0]              DATA_BITS,
  input logic [7:0]              BIT_CYCLES,
  input logic                    USER_CHECK_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // Busy lasts 21 cycles; split because repetitions stay short
  sequence s_busy_run;
    PROG_BUSY[*8] ##1 PROG_BUSY[*8] ##1 PROG_BUSY[*5];
  endsequence
  sequence s_prog_taken;
    PROG_EXEC && CFG_VALID && !PROG_BUSY && !CFG.lock;
  endsequence

  AST_RD_ANSWER: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
  AST_RANGE_FIXED: assert property (REG_RD && REG_ADDR == otp_cfg_pkg::ADDR_RANGE
    |=> REG_RDATA[7:3] == otp_cfg_pkg::RANGE_FIXED) else $error("range pattern wrong");
  AST_RO_REFUSED: assert property (REG_WR && REG_ADDR == otp_cfg_pkg::ADDR_RANGE && CFG_VALID
    && !PROG_BUSY |=> REG_WR_REFUSED) else $error("range write not refused");
  AST_LOCK_REFUSED: assert property (REG_WR && CFG.lock |=> REG_WR_REFUSED)
    else $error("write after lock not refused");
  AST_PROG_SPAN: assert property (s_prog_taken |=> s_busy_run ##1 !PROG_BUSY)
    else $error("programming span wrong");
  AST_CHECK_EN: assert property (USER_CHECK_EN == CFG.lock) else $error("user check enable wrong");
  AST_PCM_GATE: assert property (PCM_OUT == ($past(PCM_MOD) & $past(CFG.pcm_en)))
    else $error("pcm output wrong");
  AST_LEN_SEL: assert property ($stable(CFG) |-> DATA_BITS == (CFG.len8 ? 4'h8 : 4'hA))
    else $error("data length wrong");
  AST_BAUD_SEL: assert property ($stable(CFG) |-> BIT_CYCLES == (CFG.baud_high ?
    otp_cfg_pkg::BIT_CYC_HIGH : otp_cfg_pkg::BIT_CYC_LOW)) else $error("bit period wrong");
  AST_PD_OFF: assert property ((!CFG.pulldown_en)[*2] |-> !SYNC_PULLDOWN_EN)
    else $error("pulldown without enable");
  AST_PD_NORUN: assert property ((CFG.pulldown_en && DAISY_MODE && CHAIN_ADDR_VALID
    && !RUN_CMD_SEEN)[*2] |-> !SYNC_PULLDOWN_EN) else $error("pulldown before run");
  AST_SYNC_BLANK: assert property ((SYNC_ACCEPT && !RESPONSE_DONE ##1 (!RESPONSE_DONE)[*3]) |=> !SYNC_ACCEPT)
    else $error("sync accepted while blanking");
endmodule

bind otp_config_bank otp_bank_chk #(.BLANK_CYCLES(BLANK_CYCLES)) chk_u (.*);

// file: verification/ecu_link_model.sv
// ECU side model: issues register reads, writes and programming commands.
// Assumes requests are taken at the rising CLK edge and answered one cycle on.
`timescale 1ns/1ps
module ecu_link_model (
  // Clock in
  input  logic       clk,
  // Request out
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd,
  output logic       prog_exec,
  // Answer in
  input  logic [7:0] reg_rdata,
  input  logic       reg_rvalid,
  input  logic       reg_wr_refused
);
  // Quiet bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    prog_exec = 1'b0;
  end

  // One-cycle strobe; address and data inverted after release so stale values never match
  task automatic strobe(input logic [1:0] kind, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= (kind == 2'h1);
    reg_rd <= (kind == 2'h2);
    prog_exec <= (kind == 2'h3);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    prog_exec <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  // Register read over the link
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    strobe(2'h2, a, 8'h00);
    d = reg_rdata;
    v = reg_rvalid;
  endtask

  // Register write; callers pick parity for short data, the advised choice
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic refused);
    strobe(2'h1, a, d);
    refused = reg_wr_refused;
  endtask

  // Execute programming of the pending user byte
  task automatic prog(output logic refused);
    strobe(2'h3, 8'h00, 8'h00);
    refused = reg_wr_refused;
  endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench of the configuration bank with the ECU model in front.
// Assumes a 20 MHz clock and a short blanking count for simulation.
`timescale 1ns/1ps
module testbench;
  logic                   CLK, RSTN;
  logic [7:0]             REG_ADDR, REG_WDATA, REG_RDATA, BIT_CYCLES;
  logic                   REG_WR, REG_RD, REG_RVALID, REG_WR_REFUSED, PROG_EXEC, PROG_BUSY;
  logic                   DAISY_MODE, CHAIN_ADDR_VALID, RUN_CMD_SEEN, SYNC_DETECTED, RESPONSE_DONE;
  logic                   SYNC_ACCEPT, SYNC_PULLDOWN_EN, PCM_MOD, PCM_OUT, CFG_VALID;
  logic [2:0]             CHAIN_ADDR;
  logic [3:0]             DATA_BITS, INIT_RANGE_CODE;
  logic                   FACTORY_CHECK_OK, USER_CHECK_EN, USER_CHECK_OK;
  otp_cfg_pkg::link_cfg_t CFG;
  logic [7:0]             rdat;
  logic                   flag;
  int                     err_total, num_checks, cyc_count;
  // Pulldown cases: daisy, addressed, run, address, expected
  localparam logic [6:0] PD_CASE [5] = '{7'h01, 7'h41, 7'h62, 7'h73, 7'h74};
  localparam logic [7:0] TRACE_BYTES [4] = '{8'h03, 8'h60, 8'h04, 8'h00};

  otp_config_bank #(.TRACE_WORD(32'h0004_6003), .FULL_SCALE(3'h7), .BLANK_CYCLES(8)) dut_u (.*);
  ecu_link_model ecu_u (.clk(CLK), .reg_addr(REG_ADDR), .reg_wr(REG_WR), .reg_wdata(REG_WDATA),
    .reg_rd(REG_RD), .prog_exec(PROG_EXEC), .reg_rdata(REG_RDATA), .reg_rvalid(REG_RVALID),
    .reg_wr_refused(REG_WR_REFUSED));

  // Clock and hang guard
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Sync pulse, then the accept seen in the following cycle
  task automatic sync_pulse(output logic acc);
    @(posedge CLK) SYNC_DETECTED <= 1'b1;
    @(posedge CLK) SYNC_DETECTED <= 1'b0;
    #1 acc = SYNC_ACCEPT;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 60 && PROG_BUSY !== 1'b0; i++) @(posedge CLK);
    @(posedge CLK);
    #1;
  endtask

  // Main sequence
  initial begin
    {RSTN, DAISY_MODE, CHAIN_ADDR_VALID, RUN_CMD_SEEN, SYNC_DETECTED, RESPONSE_DONE, PCM_MOD} = 7'h00;
    CHAIN_ADDR = 3'h0;
    err_total = 0;
    num_checks = 0;
    cyc_count = 0;
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    for (int i = 0; i < 20 && CFG_VALID !== 1'b1; i++) @(posedge CLK);
    #1 chk("cfg_valid", 1, CFG_VALID);
    for (int i = 0; i < 4; i++) begin
      ecu_u.rd(8'(i), rdat, flag);
      chk("trace byte", TRACE_BYTES[i], rdat);
      chk("read valid", 1, flag);
    end
    ecu_u.rd(otp_cfg_pkg::ADDR_RANGE, rdat, flag);
    chk("range reg", 8'h27, rdat);
    chk("init range", 4'hA, INIT_RANGE_CODE);
    chk("factory check", 1, FACTORY_CHECK_OK);
    ecu_u.rd(otp_cfg_pkg::ADDR_USER, rdat, flag);
    chk("user reset", 8'h00, rdat);
    chk("cfg reset", 8'h00, CFG);
    ecu_u.rd(8'h0A, rdat, flag);
    chk("unmapped read", 8'h00, rdat);
    ecu_u.wr(otp_cfg_pkg::ADDR_RANGE, 8'hFF, flag);
    chk("range write refused", 1, flag);
    ecu_u.rd(otp_cfg_pkg::ADDR_RANGE, rdat, flag);
    chk("range kept", 8'h27, rdat);
    @(posedge CLK) PCM_MOD <= 1'b1;
    repeat (3) @(posedge CLK);
    #1 chk("pcm low", 0, PCM_OUT);
    chk("pulldown off", 0, SYNC_PULLDOWN_EN);
    // Program pcm, pulldown, 8-bit data, parity and high baud
    ecu_u.wr(otp_cfg_pkg::ADDR_USER, 8'h69, flag);
    chk("user write ok", 0, flag);
    ecu_u.rd(otp_cfg_pkg::ADDR_USER, rdat, flag);
    chk("pending byte", 8'h69, rdat);
    chk("cfg before prog", 8'h00, CFG);
    ecu_u.prog(flag);
    wait_idle();
    chk("cfg programmed", 8'h69, CFG);
    chk("data bits", otp_cfg_pkg::LEN_SHORT, DATA_BITS);
    chk("bit cycles", otp_cfg_pkg::BIT_CYC_HIGH, BIT_CYCLES);
    chk("pcm passes", 1, PCM_OUT);
    for (int i = 0; i < 5; i++) begin
      @(posedge CLK) {DAISY_MODE, CHAIN_ADDR_VALID, RUN_CMD_SEEN, CHAIN_ADDR} <= PD_CASE[i][6:1];
      repeat (3) @(posedge CLK);
      #1 chk("pulldown case", PD_CASE[i][0], SYNC_PULLDOWN_EN);
    end
    @(posedge CLK) DAISY_MODE <= 1'b0;
    sync_pulse(flag);
    chk("sync accepted", 1, flag);
    repeat (4) @(posedge CLK);
    sync_pulse(flag);
    chk("sync blanked", 0, flag);
    @(posedge CLK) RESPONSE_DONE <= 1'b1;
    @(posedge CLK) RESPONSE_DONE <= 1'b0;
    repeat (12) @(posedge CLK);
    sync_pulse(flag);
    chk("sync after blank", 1, flag);
    // Lock with slot blanking, slot latency, 10-bit data and parity kept
    ecu_u.wr(otp_cfg_pkg::ADDR_USER, 8'hF5, flag);
    ecu_u.prog(flag);
    wait_idle();
    chk("locked cfg", 8'hF5, CFG);
    chk("data bits long", otp_cfg_pkg::LEN_LONG, DATA_BITS);
    chk("user check on", 1, USER_CHECK_EN);
    chk("user check ok", 1, USER_CHECK_OK);
    // Slot blanking: a finished response reopens at once, before the fixed time
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK) RESPONSE_DONE <= 1'b1;
      @(posedge CLK) RESPONSE_DONE <= 1'b0;
      sync_pulse(flag);
      chk("slot sync", 1, flag);
    end
    ecu_u.wr(otp_cfg_pkg::ADDR_USER, 8'h00, flag);
    chk("locked write", 1, flag);
    ecu_u.prog(flag);
    chk("locked prog", 1, flag);
    tally_and_finish();
  end
endmodule
